// ### dv/mpc_cfg_monitor.sv
// Port checker for the configuration word
`timescale 1ns/100ps
`default_nettype none
module mpc_cfg_monitor (
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire mpc_pkg::mpc_wr_t i_wr,
    input wire logic [7:0]       i_rd_cmd,
    input wire logic [15:0]      o_rd_data,
    input wire logic             i_low_power_mode,
    input wire logic             o_batt_current_output_on,
    input wire logic             o_system_power_output_on,
    input wire logic             o_low_power_throttle_on,
    input wire logic             o_input_shunt_20mohm,
    input wire logic             o_charge_shunt_20mohm,
    input wire logic             o_power_monitor_gain_1ua,
    input wire logic             o_input_switches_off,
    input wire logic             o_charger_good_signal,
    input wire logic             o_ship_discharge_on
);
    import mpc_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic hit;
    // A write aimed at this word
    assign hit = i_wr.valid && i_wr.cmd == 8'h30;
    property p_rd0; i_rd_cmd != 8'h30 |=> o_rd_data == 16'h0000; endproperty
    property p_back;
        hit ##1 i_rd_cmd == 8'h30 |=>
            o_rd_data[15:2] == $past(i_wr.data[15:2], 2);
    endproperty
    property p_batt;
        hit |=> o_batt_current_output_on ==
                ($past(i_wr.data[15]) && !i_low_power_mode);
    endproperty
    property p_lp;
        i_low_power_mode |->
            !o_batt_current_output_on && !o_system_power_output_on;
    endproperty
    property p_thr;
        hit |=> o_low_power_throttle_on == ($past(i_wr.data[14:13]) == 2'h2);
    endproperty
    property p_shunt;
        hit |=> {o_input_shunt_20mohm, o_charge_shunt_20mohm,
                 o_power_monitor_gain_1ua} == $past(i_wr.data[11:9]);
    endproperty
    property p_cut; o_input_switches_off |-> !o_charger_good_signal; endproperty
    property p_ship; hit && i_wr.data[1] |=> o_ship_discharge_on; endproperty
    a_rd0: assert property (p_rd0) else $error("bad idle read");
    a_back: assert property (p_back) else $error("bad readback");
    a_batt: assert property (p_batt) else $error("bad batt");
    a_lp: assert property (p_lp) else $error("low power");
    a_thr: assert property (p_thr) else $error("bad throttle");
    a_shunt: assert property (p_shunt) else $error("bad shunt");
    a_cut: assert property (p_cut) else $error("good high");
    a_ship: assert property (p_ship) else $error("no ship");
    c_wr: cover property (hit);
    c_cut: cover property (o_input_switches_off);
    c_ship: cover property ($fell(o_ship_discharge_on));
endmodule
bind mpc_config_word mpc_cfg_monitor mpc_cfg_monitor_inst (.*);
`default_nettype wire

// ### dv/mpc_host_model.sv
// Host model issuing word writes and reads
`timescale 1ns/100ps
`default_nettype none
module mpc_host_model (
    input  wire logic         i_core_clk,
    input  wire logic [15:0]  i_rd_data,
    output var mpc_pkg::mpc_wr_t o_wr,
    output logic [7:0]        o_rd_cmd
);
    import mpc_pkg::*;
    // Idle; reads parked on the word
    initial begin
        o_wr = '0;
        o_rd_cmd = 8'h30;
    end
    // Throttle mode only written with no adapter modelled
    task automatic write_word(input logic [15:0] d);
        @(posedge i_core_clk) o_wr <= '{1'b1, 8'h30, d};
        @(posedge i_core_clk) o_wr <= '{1'b0, 8'hCF, ~d};
        #1;
    endtask
    // Answer comes one edge after the command; reads park on the word again
    task automatic read_word(input logic [7:0] c, output logic [15:0] d);
        @(posedge i_core_clk) o_rd_cmd <= c;
        @(posedge i_core_clk) #1 d = i_rd_data;
        @(posedge i_core_clk) o_rd_cmd <= 8'h30;
        #1;
    endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Testbench for the configuration word
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mpc_pkg::*;
    logic clk, rst, lp, pin, cmp, below, cg;
    logic bo, so, tho, isx, csx, gn, hz, pt, co, off, good, sh, wk;
    logic [15:0] rd, q;
    logic [7:0] cmd;
    mpc_wr_t wr;
    int miscompares, samples_checked, cycles;
    mpc_config_word #(.DEG_MID_CYCLES(40'd20), .DEG_LONG_CYCLES(40'd40),
        .SHIP_CYCLES(40'd30), .WAKE_CYCLES(40'd50)) mpc_config_word_inst (
        .i_core_clk(clk), .i_rst(rst), .i_wr(wr), .i_rd_cmd(cmd),
        .o_rd_data(rd), .i_low_power_mode(lp), .i_input_limit_pin(pin),
        .i_comparator_raw(cmp), .i_batt_below_min_sys(below),
        .i_charger_good_raw(cg), .o_batt_current_output_on(bo),
        .o_system_power_output_on(so), .o_low_power_throttle_on(tho),
        .o_input_shunt_20mohm(isx), .o_charge_shunt_20mohm(csx),
        .o_power_monitor_gain_1ua(gn), .o_high_impedance_mode(hz),
        .o_pass_through_mode(pt), .o_comparator_output(co),
        .o_input_switches_off(off), .o_charger_good_signal(good),
        .o_ship_discharge_on(sh), .o_wakeup_charge_on(wk));
    mpc_host_model mpc_host_model_inst (.i_core_clk(clk), .i_rd_data(rd),
        .o_wr(wr), .o_rd_cmd(cmd));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Comparison and run helpers
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Field outputs, low power override and throttle codes
    task automatic t_fields;
        mpc_host_model_inst.write_word(16'h9E00);
        check({bo, so, isx, csx, gn}, 5'h1F);
        @(posedge clk) lp <= 1'b1;
        #1 check({bo, so}, 2'b00);
        @(posedge clk) lp <= 1'b0;
        cg <= 1'b0;
        #1 check(good, 1'b0);
        @(posedge clk) cg <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            mpc_host_model_inst.write_word({1'b0, 2'(k), 13'h0});
            check({tho, gn}, {k == 2, 1'b0});
        end
        @(posedge clk) pin <= 1'b0;
        tick(6);
        check({hz, pt}, 2'b10);
        mpc_host_model_inst.write_word(16'h0100);
        check({hz, pt}, 2'b01);
        @(posedge clk) pin <= 1'b1;
        $display("fields done");
    endtask
    // Ship discharge and auto wakeup self clearing
    task automatic t_self;
        mpc_host_model_inst.write_word(16'h0002);
        check(sh, 1'b1);
        tick(29);
        check(sh, 1'b1);
        tick(1);
        check(sh, 1'b0);
        @(posedge clk) below <= 1'b1;
        tick(6);
        mpc_host_model_inst.write_word(16'h0001);
        tick(1);
        check(wk, 1'b1);
        @(posedge clk) below <= 1'b0;
        tick(6);
        check(wk, 1'b0);
        mpc_host_model_inst.read_word(8'h30, q);
        check(q, 16'h0000);
        // Charge that stays below minimum ends on the time limit
        @(posedge clk) below <= 1'b1;
        tick(6);
        mpc_host_model_inst.write_word(16'h0001);
        tick(50);
        check(wk, 1'b1);
        tick(1);
        check(wk, 1'b0);
        mpc_host_model_inst.read_word(8'h30, q);
        check(q, 16'h0000);
        @(posedge clk) below <= 1'b0;
        tick(6);
        $display("self clear done");
    endtask
    // Every deglitch code, with the cutoff armed
    task automatic t_cmp;
        int lim [4] = '{20, 25, 20, 40};
        for (int k = 0; k < 4; k++) begin
            mpc_host_model_inst.write_word(16'h0008 | 16'(k << 4));
            @(posedge clk) cmp <= 1'b0;
            tick(lim[k] + 3);
            check(co, 1'b1);
            tick(2);
            check({co, off, good}, {k == 0, k != 0, k == 0});
            @(posedge clk) cmp <= 1'b1;
            tick(5);
            check({co, off}, {1'b1, k != 0});
            mpc_host_model_inst.write_word(16'h0000);
            tick(1);
            check({off, good}, 2'b01);
        end
        $display("comparator done");
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            close_out();
        end
    end
    // Reset, reset value, then the scenarios
    initial begin
        rst = 1'b1;
        {lp, below} = 2'b00;
        {pin, cmp, cg} = 3'h7;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        check(rd, 16'h0211);
        mpc_host_model_inst.read_word(8'h31, q);
        check(q, 16'h0000);
        t_fields();
        t_self();
        t_cmp();
        // Reset in mid-run brings back the reset word
        mpc_host_model_inst.write_word(16'hFFFC);
        @(posedge clk) rst <= 1'b1;
        tick(2);
        check(rd, 16'h0000);
        @(posedge clk) rst <= 1'b0;
        tick(1);
        check(rd, 16'h0211);
        $display("mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/mpc_config_word.sv
// Monitor and pin configuration register with its self-acting fields
`timescale 1ns/100ps
`default_nettype none
`include "mpc_defines.svh"
module mpc_config_word #(
    parameter logic [39:0] DEG_MID_CYCLES  = 40'(`MPC_DEG_MID_MS * `MPC_CLK_KHZ),
    parameter logic [39:0] DEG_LONG_CYCLES =
        40'(`MPC_DEG_LONG_S * 64'd1000 * `MPC_CLK_KHZ),
    parameter logic [39:0] SHIP_CYCLES     = 40'(`MPC_SHIP_MS * `MPC_CLK_KHZ),
    parameter logic [39:0] WAKE_CYCLES     =
        40'(`MPC_WAKE_MIN * 64'd60000 * `MPC_CLK_KHZ)
) (
    input  wire logic            i_core_clk,
    input  wire logic            i_rst,
    input  wire mpc_pkg::mpc_wr_t i_wr,
    input  wire logic [7:0]      i_rd_cmd,
    output logic [15:0]          o_rd_data,
    input  wire logic            i_low_power_mode,
    input  wire logic            i_input_limit_pin,
    input  wire logic            i_comparator_raw,
    input  wire logic            i_batt_below_min_sys,
    input  wire logic            i_charger_good_raw,
    output logic                 o_batt_current_output_on,
    output logic                 o_system_power_output_on,
    output logic                 o_low_power_throttle_on,
    output logic                 o_input_shunt_20mohm,
    output logic                 o_charge_shunt_20mohm,
    output logic                 o_power_monitor_gain_1ua,
    output logic                 o_high_impedance_mode,
    output logic                 o_pass_through_mode,
    output logic                 o_comparator_output,
    output logic                 o_input_switches_off,
    output logic                 o_charger_good_signal,
    output logic                 o_ship_discharge_on,
    output logic                 o_wakeup_charge_on
);
    import mpc_pkg::*;

    localparam logic [39:0] DEG_SHORT_CYCLES =
        40'(`MPC_DEG_SHORT_US * `MPC_CLK_KHZ / 64'd1000);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: limit pin, comparator, battery level
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_stable;
    logic [2:0] next_pin_stable;
    logic [2:0] pin_raw;

    assign pin_raw = {i_batt_below_min_sys, i_comparator_raw,
                      i_input_limit_pin};

    // Accept a change once the second and third stages agree
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            next_pin_stable[k] = (sync2[k] == sync3[k]) ? sync3[k]
                                                        : pin_stable[k];
        end
    end

    // Sync stages; stable copies reset to idle levels
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1      <= 3'h3;
            sync2      <= 3'h3;
            sync3      <= 3'h3;
            pin_stable <= 3'h3;
        end else begin
            sync1      <= pin_raw;
            sync2      <= sync1;
            sync3      <= sync2;
            pin_stable <= next_pin_stable;
        end
    end

    logic limit_pin;
    logic cmp_in;
    logic below_min;
    assign limit_pin = pin_stable[0];
    assign cmp_in    = pin_stable[1];
    assign below_min = pin_stable[2];

    ////////////////////////////////////////////////////////////////////////
    // Configuration word and its timers
    mpc_cfg_t        cfg;
    mpc_cfg_t        next_cfg;
    logic [39:0]     ship_cnt;
    logic [39:0]     next_ship_cnt;
    mpc_wake_state_t wake_state;
    mpc_wake_state_t next_wake_state;
    logic [39:0]     wake_cnt;
    logic [39:0]     next_wake_cnt;
    logic            ship_done;
    logic            wake_done;

    // Ship-mode discharge runs while the bit is set
    always_comb begin
        ship_done     = 1'b0;
        next_ship_cnt = 40'h0;
        if (cfg.ship_discharge_enable) begin
            if (ship_cnt >= SHIP_CYCLES - 40'h1) begin
                ship_done = 1'b1;
            end else begin
                next_ship_cnt = ship_cnt + 40'h1;
            end
        end
    end

    // Auto wakeup charge sequence
    always_comb begin
        next_wake_state = wake_state;
        next_wake_cnt   = 40'h0;
        wake_done       = 1'b0;
        case (wake_state)
            MPC_WAKE_IDLE: begin
                if (cfg.auto_wakeup_enable && below_min) begin
                    next_wake_state = MPC_WAKE_CHARGING;
                end
            end
            MPC_WAKE_CHARGING: begin
                if (!cfg.auto_wakeup_enable) begin
                    next_wake_state = MPC_WAKE_IDLE;
                end else if (!below_min ||
                             wake_cnt >= WAKE_CYCLES - 40'h1) begin
                    next_wake_state = MPC_WAKE_IDLE;
                    wake_done       = 1'b1;
                end else begin
                    next_wake_cnt = wake_cnt + 40'h1;
                end
            end
            default: next_wake_state = MPC_WAKE_IDLE;
        endcase
    end

    // Self clears first; a completed host write takes priority
    always_comb begin
        next_cfg = cfg;
        if (ship_done) begin
            next_cfg.ship_discharge_enable = 1'b0;
        end
        if (wake_done) begin
            next_cfg.auto_wakeup_enable = 1'b0;
        end
        if (i_wr.valid && i_wr.cmd == `MPC_CMD_ADDR) begin
            next_cfg = mpc_cfg_t'(i_wr.data);
        end
    end

    // Register word and timer state
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg        <= mpc_cfg_t'(`MPC_RESET_VALUE);
            ship_cnt   <= 40'h0;
            wake_state <= MPC_WAKE_IDLE;
            wake_cnt   <= 40'h0;
        end else begin
            cfg        <= next_cfg;
            ship_cnt   <= next_ship_cnt;
            wake_state <= next_wake_state;
            wake_cnt   <= next_wake_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Independent comparator deglitch and path cutoff
    logic        cmp_out;
    logic        next_cmp_out;
    logic [39:0] deg_cnt;
    logic [39:0] next_deg_cnt;
    logic [39:0] deg_limit;
    logic        latched_off;
    logic        next_latched_off;

    // Falling edge waits the selected time, rising edge passes at once
    always_comb begin
        if (cfg.comparator_deglitch_select == `MPC_DEG_1US) begin
            deg_limit = DEG_SHORT_CYCLES;
        end else if (cfg.comparator_deglitch_select == `MPC_DEG_2MS) begin
            deg_limit = DEG_MID_CYCLES;
        end else begin
            deg_limit = DEG_LONG_CYCLES;
        end
        next_cmp_out = cmp_out;
        next_deg_cnt = 40'h0;
        if (cfg.comparator_deglitch_select == `MPC_DEG_OFF) begin
            next_cmp_out = 1'b1;
        end else if (cmp_in) begin
            next_cmp_out = 1'b1;
        end else if (cmp_out) begin
            if (deg_cnt >= deg_limit - 40'h1) begin
                next_cmp_out = 1'b0;
            end else begin
                next_deg_cnt = deg_cnt + 40'h1;
            end
        end
        // Trip holds the path off until the cutoff bit is cleared
        next_latched_off = cfg.forced_path_cutoff &&
                           (latched_off || !cmp_out);
    end

    // Comparator state
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cmp_out     <= 1'b1;
            deg_cnt     <= 40'h0;
            latched_off <= 1'b0;
        end else begin
            cmp_out     <= next_cmp_out;
            deg_cnt     <= next_deg_cnt;
            latched_off <= next_latched_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: live word when the command matches, else zero
    logic [15:0] next_rd_data;
    always_comb begin
        next_rd_data = 16'h0000;
        if (i_rd_cmd == `MPC_CMD_ADDR) begin
            next_rd_data = cfg;
        end
    end

    // Read data register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= 16'h0000;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field effects on the analog controls
    assign o_batt_current_output_on = cfg.batt_current_monitor_enable &&
                                      !i_low_power_mode;
    assign o_system_power_output_on = cfg.power_monitor_enable &&
                                      !i_low_power_mode;
    assign o_low_power_throttle_on  = cfg.low_power_throttle_select ==
                                      `MPC_THROTTLE_SYSTEM_RAIL_VOLTAGE;
    assign o_input_shunt_20mohm     = cfg.input_shunt_select;
    assign o_charge_shunt_20mohm    = cfg.charge_shunt_select;
    assign o_power_monitor_gain_1ua = cfg.power_monitor_gain;
    assign o_high_impedance_mode    = !limit_pin &&
                                      !cfg.limit_pin_function_select;
    assign o_pass_through_mode      = (!limit_pin &&
                                       cfg.limit_pin_function_select) ||
                                      cfg.pass_through_enable;
    assign o_comparator_output      = cmp_out;
    assign o_input_switches_off     = latched_off;
    assign o_charger_good_signal    = i_charger_good_raw &&
                                      !latched_off;
    assign o_ship_discharge_on      = cfg.ship_discharge_enable;
    assign o_wakeup_charge_on       = wake_state == MPC_WAKE_CHARGING;
endmodule
`default_nettype wire

// ### verilog/mpc_defines.svh
// Constants for the monitor and pin configuration word
// Behaviour
// - 16-bit word at command 30h, resets 0211h
// - Bit 15 battery current monitor, low power forces off
// - Bits 14-13: 10b enables rail-voltage throttling
// - Bit 12 power monitor, low power forces off
// - Bit 11 input shunt: 10 or 20 milliohm
// - Bit 10 charge shunt: 10 or 20 milliohm
// - Bit 9 power monitor gain 0.25 or 1
// - Bit 8: limit pin low gives Hi-Z or pass-through
// - Bits 5-4 comparator enable and falling-edge deglitch
// - Bit 1 discharges 140 ms, then self clears
// - Bit 0 wakeup charge 30 min, clears when done
// - Comparator trip with bit 3 cuts path, good low
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH
`define MPC_CMD_ADDR      8'h30
`define MPC_RESET_VALUE   16'h0211
`define MPC_THROTTLE_SYSTEM_RAIL_VOLTAGE 2'h2
`define MPC_DEG_OFF       2'h0
`define MPC_DEG_1US       2'h1
`define MPC_DEG_2MS       2'h2
`define MPC_CLK_KHZ       64'd25000
`define MPC_DEG_SHORT_US  64'd1
`define MPC_DEG_MID_MS    64'd2
`define MPC_DEG_LONG_S    64'd5
`define MPC_SHIP_MS       64'd140
`define MPC_WAKE_MIN      64'd30
`endif

// ### verilog/mpc_pkg.sv
// Types for the monitor and pin configuration word
package mpc_pkg;
    typedef struct packed {
        logic       batt_current_monitor_enable;
        logic [1:0] low_power_throttle_select;
        logic       power_monitor_enable;
        logic       input_shunt_select;
        logic       charge_shunt_select;
        logic       power_monitor_gain;
        logic       limit_pin_function_select;
        logic       comparator_ref_select;
        logic       comparator_polarity;
        logic [1:0] comparator_deglitch_select;
        logic       forced_path_cutoff;
        logic       pass_through_enable;
        logic       ship_discharge_enable;
        logic       auto_wakeup_enable;
    } mpc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [15:0] data;
    } mpc_wr_t;

    typedef enum logic [0:0] {
        MPC_WAKE_IDLE,
        MPC_WAKE_CHARGING
    } mpc_wake_state_t;
endpackage
